// ### design/mqrc_pkg.sv
// Package: constants and types for the multi-queue reset control block
package mqrc_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int MQRC_QUEUES = 4;
  localparam int MQRC_QW = 2;
  localparam int MQRC_PW = 16;
  localparam int MQRC_OFSW = 16;
  // ----------------------------------------
  // Default offsets and reset values
  // ----------------------------------------
  localparam logic [15:0] MQRC_OFS_LOW = 16'h0008;
  localparam logic [15:0] MQRC_OFS_HIGH = 16'h0080;
  localparam logic [15:0] MQRC_OFS_RESET = 16'h0000;
  localparam logic [15:0] MQRC_PTR_RESET = 16'h0000;
  localparam logic [1:0] MQRC_QSEL_RESET = 2'h0;
  // ----------------------------------------
  // Cycle counts
  // ----------------------------------------
  localparam int MQRC_SEL_HOLD_CYC = 2;
  localparam int MQRC_LOAD_CYC = 8;
  // ----------------------------------------
  // States
  // ----------------------------------------
  typedef enum logic [1:0] {MQRC_RESET, MQRC_LOADING, MQRC_WAIT_SERIAL, MQRC_READY} mqrc_state_t;
endpackage

// ### design/mqrc_top.sv
// Top module: full reset, strap capture, setup state and per-queue pointer reset
// Notes on behaviour
// - A low pulse on the full reset input is a full reset.
// - Full reset returns every setup and control register to unprogrammed state.
// - Straps are held during full reset and latched to fix functionality.
// - Programming source strap sampled at full reset: serial load or defaults.
// - Threshold strap sampled at full reset chooses almost-empty/full offsets.
// - No read or write operation before programming has finished.
// - Pointer reset clears read and write pointers of one queue only.
// - Pointer reset leaves all setup contents unchanged.
// - Source low needs serial load; high configures defaults, refuses serial.
// - Defaults: threshold low gives offsets 8, high gives 128.
// - Serial enable output goes low when programming completes and serial enable in is low.
`timescale 1ns/1ps
module mqrc_top
  import mqrc_pkg::*;
#(
  parameter int QUEUES = MQRC_QUEUES,
  parameter int LOAD_CYC = MQRC_LOAD_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Reset pins
  input wire logic full_reset_in,
  input wire logic queue_pointer_reset_in,
  // Straps
  input wire logic flag_bus_style_select,
  input wire logic input_width_select,
  input wire logic output_width_select,
  input wire logic primary_chip_select,
  input wire logic [2:0] chip_identity_bits,
  input wire logic program_source_select,
  input wire logic threshold_default_select,
  // Serial programming handshake
  input wire logic serial_enable_in,
  input wire logic serial_load_done,
  input wire logic [MQRC_OFSW-1:0] serial_offset,
  // Queue access
  input wire logic wr_sel_en,
  input wire logic [MQRC_QW-1:0] wr_sel_q,
  input wire logic rd_sel_en,
  input wire logic [MQRC_QW-1:0] rd_sel_q,
  input wire logic wr_en,
  input wire logic rd_en,
  // Configuration and status
  output logic cfg_flag_bus_style,
  output logic cfg_input_width,
  output logic cfg_output_width,
  output logic cfg_primary_chip,
  output logic [2:0] cfg_chip_identity,
  output logic cfg_default_mode,
  output logic [MQRC_OFSW-1:0] cfg_offset,
  output logic serial_enable_out,
  output logic access_allowed,
  output logic wr_accept,
  output logic rd_accept,
  output logic [MQRC_QW-1:0] wr_q,
  output logic [MQRC_QW-1:0] rd_q,
  output logic [QUEUES*MQRC_PW-1:0] wr_ptr_flat,
  output logic [QUEUES*MQRC_PW-1:0] rd_ptr_flat
);
  // ----------------------------------------
  // Pin synchronisers (three stages)
  // ----------------------------------------
  logic [2:0] fr_sync, pr_sync;
  logic fr_low, pr_low, pr_low_d;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fr_sync <= 3'h7;
      pr_sync <= 3'h7;
      fr_low <= 1'b0;
      pr_low <= 1'b0;
      pr_low_d <= 1'b0;
    end else begin
      fr_sync <= {fr_sync[1:0], full_reset_in};
      pr_sync <= {pr_sync[1:0], queue_pointer_reset_in};
      if (fr_sync[2] == fr_sync[1]) begin
        fr_low <= ~fr_sync[2];
      end
      if (pr_sync[2] == pr_sync[1]) begin
        pr_low <= ~pr_sync[2];
      end
      pr_low_d <= pr_low;
    end
  end
  wire fr_active = fr_low;
  wire pr_start = pr_low & ~pr_low_d;
  // ----------------------------------------
  // Setup state
  // ----------------------------------------
  mqrc_state_t state, next_state;
  logic [7:0] load_cnt, next_load_cnt;
  logic next_fbs, next_iw, next_ow, next_pri, next_dm;
  logic [2:0] next_id;
  logic [MQRC_OFSW-1:0] next_ofs;
  logic thr_strap, next_thr_strap;
  always_comb begin
    next_state = state;
    next_load_cnt = load_cnt;
    next_fbs = cfg_flag_bus_style;
    next_iw = cfg_input_width;
    next_ow = cfg_output_width;
    next_pri = cfg_primary_chip;
    next_id = cfg_chip_identity;
    next_dm = cfg_default_mode;
    next_ofs = cfg_offset;
    next_thr_strap = thr_strap;
    if (fr_active) begin
      next_state = MQRC_RESET;
      next_load_cnt = 8'h00;
      next_ofs = MQRC_OFS_RESET;
      next_fbs = flag_bus_style_select;
      next_iw = input_width_select;
      next_ow = output_width_select;
      next_pri = primary_chip_select;
      next_id = chip_identity_bits;
      next_dm = program_source_select;
      next_thr_strap = threshold_default_select;
    end else begin
      case (state)
        MQRC_RESET: begin
          next_state = cfg_default_mode ? MQRC_LOADING : MQRC_WAIT_SERIAL;
        end
        MQRC_LOADING: begin
          // Default load spends write clocks, as the device would
          if (load_cnt == 8'(LOAD_CYC - 1)) begin
            next_ofs = thr_strap ? MQRC_OFS_HIGH : MQRC_OFS_LOW;
            next_state = MQRC_READY;
          end else begin
            next_load_cnt = load_cnt + 8'h01;
          end
        end
        MQRC_WAIT_SERIAL: begin
          // Serial load is only accepted in serial mode
          if (serial_load_done) begin
            next_ofs = serial_offset;
            next_state = MQRC_READY;
          end
        end
        default: begin
          next_state = MQRC_READY;
        end
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= MQRC_RESET;
      load_cnt <= 8'h00;
      cfg_flag_bus_style <= 1'b0;
      cfg_input_width <= 1'b0;
      cfg_output_width <= 1'b0;
      cfg_primary_chip <= 1'b0;
      cfg_chip_identity <= 3'h0;
      cfg_default_mode <= 1'b0;
      cfg_offset <= MQRC_OFS_RESET;
      thr_strap <= 1'b0;
    end else begin
      state <= next_state;
      load_cnt <= next_load_cnt;
      cfg_flag_bus_style <= next_fbs;
      cfg_input_width <= next_iw;
      cfg_output_width <= next_ow;
      cfg_primary_chip <= next_pri;
      cfg_chip_identity <= next_id;
      cfg_default_mode <= next_dm;
      cfg_offset <= next_ofs;
      thr_strap <= next_thr_strap;
    end
  end
  wire ready = (state == MQRC_READY);
  // Follows serial enable in once programmed, as a chain needs
  assign serial_enable_out = ~(ready & ~serial_enable_in);
  assign access_allowed = ready & ~fr_active;
  assign wr_accept = access_allowed & wr_en & ~pr_low;
  assign rd_accept = access_allowed & rd_en & ~pr_low;
  // ----------------------------------------
  // Queue selection and pointers
  // ----------------------------------------
  logic [MQRC_QW-1:0] next_wr_q, next_rd_q;
  logic [MQRC_PW-1:0] wp [QUEUES];
  logic [MQRC_PW-1:0] rp [QUEUES];
  logic [MQRC_PW-1:0] next_wp [QUEUES];
  logic [MQRC_PW-1:0] next_rp [QUEUES];
  always_comb begin
    next_wr_q = wr_q;
    next_rd_q = rd_q;
    for (int i = 0; i < QUEUES; i++) begin
      next_wp[i] = wp[i];
      next_rp[i] = rp[i];
    end
    if (fr_active) begin
      next_wr_q = MQRC_QSEL_RESET;
      next_rd_q = MQRC_QSEL_RESET;
      for (int i = 0; i < QUEUES; i++) begin
        next_wp[i] = MQRC_PTR_RESET;
        next_rp[i] = MQRC_PTR_RESET;
      end
    end else if (access_allowed) begin
      if (wr_sel_en) begin
        next_wr_q = wr_sel_q;
      end
      if (rd_sel_en) begin
        next_rd_q = rd_sel_q;
      end
      // Host has held the selection on both ports beforehand
      if (pr_start) begin
        next_wp[wr_q] = MQRC_PTR_RESET;
        next_rp[wr_q] = MQRC_PTR_RESET;
      end else begin
        if (wr_accept) begin
          next_wp[wr_q] = wp[wr_q] + 16'h0001;
        end
        if (rd_accept) begin
          next_rp[rd_q] = rp[rd_q] + 16'h0001;
        end
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_q <= MQRC_QSEL_RESET;
      rd_q <= MQRC_QSEL_RESET;
      for (int i = 0; i < QUEUES; i++) begin
        wp[i] <= MQRC_PTR_RESET;
        rp[i] <= MQRC_PTR_RESET;
      end
    end else begin
      wr_q <= next_wr_q;
      rd_q <= next_rd_q;
      for (int i = 0; i < QUEUES; i++) begin
        wp[i] <= next_wp[i];
        rp[i] <= next_rp[i];
      end
    end
  end
  genvar g;
  generate
    for (g = 0; g < QUEUES; g++) begin : g_flat
      assign wr_ptr_flat[g*MQRC_PW +: MQRC_PW] = wp[g];
      assign rd_ptr_flat[g*MQRC_PW +: MQRC_PW] = rp[g];
    end
  endgenerate
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  full_reset_clr_a: assert property (@(posedge clk) disable iff (!rst_b)
    fr_active |=> (cfg_offset == MQRC_OFS_RESET) && !ready) else $error("setup not cleared");
  strap_latch_a: assert property (@(posedge clk) disable iff (!rst_b)
    fr_active |=> cfg_chip_identity == $past(chip_identity_bits)) else $error("strap not latched");
  mode_latch_a: assert property (@(posedge clk) disable iff (!rst_b)
    fr_active |=> cfg_default_mode == $past(program_source_select)) else $error("mode not latched");
  default_ofs_a: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(ready) && cfg_default_mode |-> cfg_offset == (thr_strap ? MQRC_OFS_HIGH : MQRC_OFS_LOW))
    else $error("wrong default offset");
  no_early_access_a: assert property (@(posedge clk) disable iff (!rst_b)
    (wr_accept || rd_accept) |-> ready && !fr_active) else $error("access before programming");
  serial_refused_a: assert property (@(posedge clk) disable iff (!rst_b)
    cfg_default_mode && ready && serial_load_done && !fr_active |=> $stable(cfg_offset))
    else $error("serial load taken in default mode");
  ptr_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    pr_start && access_allowed |=> wp[$past(wr_q)] == 16'h0000 && rp[$past(wr_q)] == 16'h0000)
    else $error("pointers not cleared");
  ptr_keep_cfg_a: assert property (@(posedge clk) disable iff (!rst_b)
    pr_start && !fr_active && ready |=> $stable(cfg_offset) && $stable(cfg_default_mode))
    else $error("setup changed by pointer reset");
  serial_enable_out_done_a: assert property (@(posedge clk) disable iff (!rst_b)
    ready && !serial_enable_in |-> !serial_enable_out) else $error("serial enable out not low");
  // Load count plus the reset state and one cycle of slack
  localparam int SERIAL_ENABLE_OUT_MAX = LOAD_CYC + 2;
  default_done_a: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(fr_active) && cfg_default_mode && !serial_enable_in |-> ##[1:SERIAL_ENABLE_OUT_MAX] !serial_enable_out)
    else $error("default load not signalled");
endmodule

// ### bench/mqrc_host.sv
// Host controller model: drives full reset, straps and serial programming
`timescale 1ns/1ps
module mqrc_host (
  // Clock
  input wire logic clk,
  // Reset and straps
  output logic full_reset_in,
  output logic [8:0] strap_bits,
  // Serial programming
  output logic serial_enable_in,
  output logic serial_load_done,
  output logic [15:0] serial_offset
);
  initial begin
    full_reset_in = 1'b1;
    strap_bits = 9'h000;
    serial_enable_in = 1'b0;
    serial_load_done = 1'b0;
    serial_offset = 16'hffff;
  end
  // Straps set before the pulse and held until the next one
  task automatic full_reset(input logic [8:0] s);
    @(negedge clk);
    strap_bits = s;
    full_reset_in = 1'b0;
    repeat (6) @(negedge clk);
    full_reset_in = 1'b1;
  endtask
  // Clock keeps running after the pulse, so loading can finish
  task automatic serial_load(input logic [15:0] ofs);
    @(negedge clk);
    serial_offset = ofs;
    serial_load_done = 1'b1;
    @(negedge clk);
    serial_load_done = 1'b0;
    serial_offset = ~ofs;
  endtask
  task automatic set_serial_enable_in(input logic v);
    serial_enable_in = v;
  endtask
endmodule

// ### bench/mqrc_tb_top.sv
// Self-checking testbench for the multi-queue reset control block
`timescale 1ns/1ps
module mqrc_tb_top;
  import mqrc_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic queue_pointer_reset_in = 1'b1;
  logic wr_sel_en = 1'b0;
  logic rd_sel_en = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [1:0] wr_sel_q = 2'h0;
  logic [1:0] rd_sel_q = 2'h0;
  logic full_reset_in, serial_enable_in, serial_load_done, serial_enable_out;
  logic access_allowed, wr_accept, rd_accept, cfg_default_mode;
  logic [8:0] strap_bits;
  wire [6:0] cfg_bits;
  logic [1:0] wr_q, rd_q;
  logic [15:0] serial_offset, cfg_offset;
  logic [63:0] wr_ptr_flat, rd_ptr_flat;
  int error_cnt = 0;
  int comparisons = 0;
  always #10 clk = ~clk;
  mqrc_host i_host (.clk(clk), .full_reset_in(full_reset_in), .strap_bits(strap_bits),
    .serial_enable_in(serial_enable_in), .serial_load_done(serial_load_done), .serial_offset(serial_offset));
  mqrc_top i_dut (.clk(clk), .rst_b(rst_b), .full_reset_in(full_reset_in),
    .queue_pointer_reset_in(queue_pointer_reset_in), .flag_bus_style_select(strap_bits[8]),
    .input_width_select(strap_bits[7]), .output_width_select(strap_bits[6]),
    .primary_chip_select(strap_bits[5]), .chip_identity_bits(strap_bits[4:2]),
    .program_source_select(strap_bits[1]), .threshold_default_select(strap_bits[0]),
    .serial_enable_in(serial_enable_in), .serial_load_done(serial_load_done), .serial_offset(serial_offset),
    .wr_sel_en(wr_sel_en), .wr_sel_q(wr_sel_q), .rd_sel_en(rd_sel_en), .rd_sel_q(rd_sel_q),
    .wr_en(wr_en), .rd_en(rd_en), .cfg_flag_bus_style(cfg_bits[6]), .cfg_input_width(cfg_bits[5]),
    .cfg_output_width(cfg_bits[4]), .cfg_primary_chip(cfg_bits[3]), .cfg_chip_identity(cfg_bits[2:0]),
    .cfg_default_mode(cfg_default_mode), .cfg_offset(cfg_offset), .serial_enable_out(serial_enable_out),
    .access_allowed(access_allowed), .wr_accept(wr_accept), .rd_accept(rd_accept), .wr_q(wr_q), .rd_q(rd_q),
    .wr_ptr_flat(wr_ptr_flat), .rd_ptr_flat(rd_ptr_flat));
  task automatic complete_run();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk_val(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic wait_serial_enable_out();
    int n;
    n = 0;
    while (serial_enable_out !== 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk_val("serial_enable_out", 16'h0000, {15'h0, serial_enable_out});
    if (n >= 20) complete_run();
  endtask
  // Selection is held two cycles before any enable or pointer reset
  task automatic drive(input logic [1:0] q, input int nw, input int nr);
    wr_sel_q = q;
    rd_sel_q = q;
    wr_sel_en = 1'b1;
    rd_sel_en = 1'b1;
    @(negedge clk);
    wr_sel_en = 1'b0;
    rd_sel_en = 1'b0;
    repeat (2) @(negedge clk);
    if (nw > 0) begin
      wr_en = 1'b1;
      repeat (nw) @(negedge clk);
      wr_en = 1'b0;
    end
    if (nr > 0) begin
      rd_en = 1'b1;
      repeat (nr) @(negedge clk);
      rd_en = 1'b0;
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_default(input logic [8:0] s);
    wr_en = 1'b1;
    wr_sel_en = 1'b1;
    fork
      i_host.full_reset(s);
      begin
        // One edge after the synced reset, so the clear has landed
        repeat (6) @(negedge clk);
        chk_val("wr_accept", 16'h0000, {15'h0, wr_accept});
        chk_val("wr_ptr_q0", 16'h0000, wr_ptr_flat[15:0]);
        chk_val("cfg_offset", MQRC_OFS_RESET, cfg_offset);
      end
    join
    repeat (8) @(negedge clk);
    chk_val("access_allowed", 16'h0000, {15'h0, access_allowed});
    wait_serial_enable_out();
    chk_val("access_allowed", 16'h0001, {15'h0, access_allowed});
    wr_en = 1'b0;
    wr_sel_en = 1'b0;
    chk_val("cfg_bits", {9'h0, s[8:2]}, {9'h0, cfg_bits});
    chk_val("cfg_default_mode", 16'h0001, {15'h0, cfg_default_mode});
    chk_val("cfg_offset", s[0] ? MQRC_OFS_HIGH : MQRC_OFS_LOW, cfg_offset);
    i_host.serial_load(16'h0033);
    chk_val("cfg_offset", s[0] ? MQRC_OFS_HIGH : MQRC_OFS_LOW, cfg_offset);
    $display("test_default done");
  endtask
  task automatic test_serial();
    i_host.full_reset(9'h0f0);
    repeat (20) @(negedge clk);
    chk_val("serial_enable_out", 16'h0001, {15'h0, serial_enable_out});
    chk_val("cfg_default_mode", 16'h0000, {15'h0, cfg_default_mode});
    i_host.serial_load(16'h0033);
    @(negedge clk);
    chk_val("serial_enable_out", 16'h0000, {15'h0, serial_enable_out});
    chk_val("cfg_offset", 16'h0033, cfg_offset);
    i_host.set_serial_enable_in(1'b1);
    @(negedge clk);
    chk_val("serial_enable_out", 16'h0001, {15'h0, serial_enable_out});
    i_host.set_serial_enable_in(1'b0);
    $display("test_serial done");
  endtask
  task automatic test_ptr_reset();
    drive(2'h1, 2, 0);
    drive(2'h2, 3, 1);
    chk_val("wr_ptr_q2", 16'h0003, wr_ptr_flat[47:32]);
    chk_val("rd_ptr_q2", 16'h0001, rd_ptr_flat[47:32]);
    chk_val("wr_q", 16'h0002, {14'h0, wr_q});
    chk_val("rd_q", 16'h0002, {14'h0, rd_q});
    queue_pointer_reset_in = 1'b0;
    repeat (4) @(negedge clk);
    queue_pointer_reset_in = 1'b1;
    repeat (6) @(negedge clk);
    chk_val("wr_ptr_q2", MQRC_PTR_RESET, wr_ptr_flat[47:32]);
    chk_val("rd_ptr_q2", MQRC_PTR_RESET, rd_ptr_flat[47:32]);
    chk_val("wr_ptr_q1", 16'h0002, wr_ptr_flat[31:16]);
    chk_val("cfg_offset", MQRC_OFS_HIGH, cfg_offset);
    $display("test_ptr_reset done");
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    test_default(9'h056);
    test_serial();
    test_default(9'h1ab);
    test_ptr_reset();
    complete_run();
  end
endmodule
